//--- core/uepsc_pkg.sv
// Constants for the endpoint status and control block
package uepsc_pkg;

  // ********************************************
  // Geometry
  // ********************************************
  localparam int unsigned EP_COUNT = 16;
  localparam int unsigned EP_IDX_W = 4;
  localparam int unsigned STAT_W   = 8;

  // ********************************************
  // Endpoint indices
  // ********************************************
  localparam logic [3:0] EP_CTRL_OUT = 4'h0;
  localparam logic [3:0] EP_CTRL_IN  = 4'h1;

  // ********************************************
  // Command groups (high nibble of the command code)
  // ********************************************
  localparam logic [3:0] CMD_GRP_STALL    = 4'h4;
  localparam logic [3:0] CMD_GRP_STATUS   = 4'h5;
  localparam logic [3:0] CMD_GRP_VALIDATE = 4'h6;
  localparam logic [3:0] CMD_GRP_CLEAR    = 4'h7;
  localparam logic [3:0] CMD_GRP_UNSTALL  = 4'h8;
  localparam logic [3:0] CMD_GRP_IMAGE    = 4'hd;

  // Lowest validate code is 0x61, clear skips 0x71
  localparam logic [3:0] CMD_VALIDATE_SKIP = 4'h0;
  localparam logic [3:0] CMD_CLEAR_SKIP    = 4'h1;

  // ********************************************
  // Status byte field positions
  // ********************************************
  localparam int unsigned BIT_STALLED   = 7;
  localparam int unsigned BIT_SEC_FULL  = 6;
  localparam int unsigned BIT_PRI_FULL  = 5;
  localparam int unsigned BIT_TOGGLE    = 4;
  localparam int unsigned BIT_SETUP_OVERWRITTEN = 3;
  localparam int unsigned BIT_SETUP     = 2;
  localparam int unsigned BIT_CPU_BUF   = 1;

  localparam logic [7:0] STATUS_RESET = 8'h00;

  typedef enum logic [1:0] {
    UEPSC_IDLE  = 2'b00,
    UEPSC_FETCH = 2'b01,
    UEPSC_ANSWER = 2'b10
  } uepsc_state_e;

endpackage

//--- core/uepsc_status_mem.sv
// Per-endpoint status byte storage with registered read port
`timescale 1ns/10ps
module uepsc_status_mem (
  input  wire logic                                clock_in,
  input  wire logic                                rstn_in,
  input  wire logic                                wr_en_in,
  input  wire logic [uepsc_pkg::EP_IDX_W-1:0]      wr_idx_in,
  input  wire logic [uepsc_pkg::STAT_W-1:0]        wr_data_in,
  input  wire logic [uepsc_pkg::EP_IDX_W-1:0]      rd_idx_in,
  output logic      [uepsc_pkg::STAT_W-1:0]        rd_data_out
);
  import uepsc_pkg::*;

  logic [STAT_W-1:0] mem_reg [EP_COUNT];

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < EP_COUNT; i++) begin
        mem_reg[i] <= STATUS_RESET;
      end
      rd_data_out <= STATUS_RESET;
    end else begin
      if (wr_en_in) begin
        mem_reg[wr_idx_in] <= wr_data_in;
      end
      rd_data_out <= mem_reg[rd_idx_in];
    end
  end

endmodule // uepsc_status_mem

//--- core/uepsc_top.sv
// Endpoint status byte keeping and command decode for the device controller
`timescale 1ns/10ps
module uepsc_top (
  input  wire logic                             clock_in,
  input  wire logic                             rstn_in,
  // Processor command port
  input  wire logic                             cmd_valid_in,
  input  wire logic [7:0]                       cmd_code_in,
  output logic                                  rd_valid_out,
  output logic      [uepsc_pkg::STAT_W-1:0]     rd_data_out,
  output logic                                  int_clear_out,
  output logic      [uepsc_pkg::EP_IDX_W-1:0]   int_clear_idx_out,
  output logic                                  busy_out,
  // Endpoint configuration
  input  wire logic [uepsc_pkg::EP_COUNT-1:0]   ep_is_in_in,
  input  wire logic [uepsc_pkg::EP_COUNT-1:0]   ep_double_buf_in,
  // Serial engine events
  input  wire logic                             sie_valid_in,
  input  wire logic [uepsc_pkg::EP_IDX_W-1:0]   sie_idx_in,
  input  wire logic                             sie_setup_token_in,
  input  wire logic                             sie_setup_done_in,
  input  wire logic                             sie_out_done_in,
  input  wire logic                             sie_in_sent_in,
  input  wire logic                             sie_setup_ack_in,
  output logic                                  sie_nak_out,
  output logic                                  sie_stall_out
);
  import uepsc_pkg::*;

  // ********************************************
  // Reset release
  // ********************************************
  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire logic rstn = rst_sync_reg;

  // ********************************************
  // Command decode
  // ********************************************
  function automatic logic grp_is(input logic [7:0] code, input logic [3:0] grp);
    grp_is = (code[7:4] == grp);
  endfunction

  uepsc_state_e state_reg;
  uepsc_state_e state_next;
  logic [7:0]   cmd_reg;
  logic [3:0]   sie_idx_reg;
  logic [4:0]   sie_ev_reg;

  wire logic [3:0] cmd_idx  = cmd_reg[3:0];
  wire logic is_stall   = grp_is(cmd_reg, CMD_GRP_STALL);
  wire logic is_unstall = grp_is(cmd_reg, CMD_GRP_UNSTALL);
  wire logic is_valid   = grp_is(cmd_reg, CMD_GRP_VALIDATE) && (cmd_idx != CMD_VALIDATE_SKIP);
  wire logic is_clear   = grp_is(cmd_reg, CMD_GRP_CLEAR) && (cmd_idx != CMD_CLEAR_SKIP);
  wire logic is_status  = grp_is(cmd_reg, CMD_GRP_STATUS);
  wire logic is_image   = grp_is(cmd_reg, CMD_GRP_IMAGE);
  wire logic is_read    = is_status || is_image;

  // ********************************************
  // Sequencer: latch, fetch status byte, modify
  // ********************************************
  wire logic take_cmd = cmd_valid_in && (state_reg == UEPSC_IDLE) && !sie_valid_in;
  wire logic take_sie = sie_valid_in && (state_reg == UEPSC_IDLE);

  always_comb begin
    case (state_reg)
      UEPSC_IDLE:   state_next = (take_cmd || take_sie) ? UEPSC_FETCH : UEPSC_IDLE;
      UEPSC_FETCH:  state_next = UEPSC_ANSWER;
      UEPSC_ANSWER: state_next = UEPSC_IDLE;
      default:      state_next = UEPSC_IDLE;
    endcase
  end

  logic is_sie_reg;
  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= UEPSC_IDLE;
      cmd_reg     <= 8'h00;
      sie_idx_reg <= 4'h0;
      sie_ev_reg  <= 5'h00;
      is_sie_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (take_sie) begin
        is_sie_reg  <= 1'b1;
        sie_idx_reg <= sie_idx_in;
        sie_ev_reg  <= {sie_setup_ack_in, sie_in_sent_in, sie_out_done_in, sie_setup_done_in, sie_setup_token_in};
        cmd_reg     <= 8'h00;
      end else if (take_cmd) begin
        is_sie_reg <= 1'b0;
        cmd_reg    <= cmd_code_in;
        sie_ev_reg <= 5'h00;
      end
    end
  end

  wire logic [3:0] cur_idx = is_sie_reg ? sie_idx_reg : cmd_idx;
  wire logic [3:0] rd_idx  = (state_reg == UEPSC_IDLE) ? (sie_valid_in ? sie_idx_in : cmd_code_in[3:0]) : cur_idx;

  logic [STAT_W-1:0] cur_stat;
  logic [STAT_W-1:0] new_stat;
  logic              mem_wr;

  uepsc_status_mem u_mem (
    .clock_in    (clock_in),
    .rstn_in     (rstn),
    .wr_en_in    (mem_wr),
    .wr_idx_in   (cur_idx),
    .wr_data_in  (new_stat),
    .rd_idx_in   (rd_idx),
    .rd_data_out (cur_stat)
  );

  // ********************************************
  // Status byte update
  // ********************************************
  wire logic ev_setup_tok  = sie_ev_reg[0];
  wire logic ev_setup_done = sie_ev_reg[1];
  wire logic ev_out_done   = sie_ev_reg[2];
  wire logic ev_in_sent    = sie_ev_reg[3];
  wire logic ev_setup_ack  = sie_ev_reg[4];
  wire logic ep_dbl        = ep_double_buf_in[cur_idx];
  wire logic ep_in         = ep_is_in_in[cur_idx];
  wire logic is_ctrl       = (cur_idx == EP_CTRL_OUT) || (cur_idx == EP_CTRL_IN);
  wire logic fetched       = (state_reg == UEPSC_FETCH);
  wire logic ep_stalled    = cur_stat[BIT_STALLED];
  wire logic buf_sel       = cur_stat[BIT_CPU_BUF];

  // OUT data refused while every buffer is full
  wire logic out_nak       = !ep_in && cur_stat[BIT_PRI_FULL] && (!ep_dbl || cur_stat[BIT_SEC_FULL]);
  // setup token lifts a control endpoint stall
  wire logic auto_unstall  = ev_setup_tok && is_ctrl && ep_stalled;
  // Packets met by STALL or NAK move neither toggle nor buffers
  wire logic pkt_taken     = (ev_out_done || ev_in_sent) && !out_nak && !ep_stalled;
  // primary buffer fills first, then the secondary
  wire logic out_fill_sec  = ep_dbl && cur_stat[BIT_PRI_FULL];
  wire logic in_drain_sec  = ep_dbl && !cur_stat[BIT_PRI_FULL];
  // validate acts on IN, clear on OUT endpoints
  wire logic buf_cmd       = (is_valid && ep_in) || (is_clear && !ep_in);
  // unstall only acts on a stalled endpoint
  wire logic cmd_unstall   = is_unstall && ep_stalled;
  // status read drops setup_overwritten once setup is stored
  wire logic ovw_release   = is_status && cur_stat[BIT_SETUP];

  function automatic int unsigned full_bit(input logic sec);
    full_bit = sec ? BIT_SEC_FULL : BIT_PRI_FULL;
  endfunction

  logic [STAT_W-1:0] sie_stat;
  logic [STAT_W-1:0] cmd_stat;
  logic              cmd_wr;

  // Serial engine side
  always_comb begin
    sie_stat = cur_stat;
    if (auto_unstall) begin
      // leaving stall flushes and returns to DATA0
      sie_stat = STATUS_RESET;
    end
    if (ev_setup_tok && is_ctrl && cur_stat[BIT_SETUP]) begin
      sie_stat[BIT_SETUP_OVERWRITTEN] = 1'b1;
    end
    if (ev_setup_done && is_ctrl) begin
      sie_stat[BIT_SETUP]    = 1'b1;
      sie_stat[BIT_PRI_FULL] = 1'b1;
      sie_stat[BIT_TOGGLE]   = 1'b1;
    end
    if (ev_setup_ack) begin
      sie_stat[BIT_SETUP] = 1'b0;
    end
    if (pkt_taken) begin
      // toggle advances on each accepted packet
      sie_stat[BIT_TOGGLE] = ~cur_stat[BIT_TOGGLE];
      // accepted OUT packet fills a buffer
      if (ev_out_done) begin
        sie_stat[full_bit(out_fill_sec)] = 1'b1;
      end else begin
        sie_stat[full_bit(in_drain_sec)] = 1'b0;
      end
    end
  end

  // Command side; an unmatched code writes nothing back
  always_comb begin
    cmd_stat = cur_stat;
    cmd_wr   = 1'b1;
    if (is_stall) begin
      cmd_stat[BIT_STALLED] = 1'b1;
    end else if (cmd_unstall) begin
      // flush and DATA0 on leaving stall
      cmd_stat = STATUS_RESET;
    end else if (buf_cmd) begin
      cmd_stat[full_bit(buf_sel)] = is_valid;
      if (is_clear) begin
        cmd_stat[BIT_SETUP] = 1'b0;
      end
      if (ep_dbl) begin
        cmd_stat[BIT_CPU_BUF] = ~buf_sel;
      end
    end else if (ovw_release) begin
      cmd_stat[BIT_SETUP_OVERWRITTEN] = 1'b0;
    end else begin
      cmd_wr = 1'b0;
    end
  end

  // reserved bit is never stored as one
  assign new_stat = is_sie_reg ? {sie_stat[7:1], 1'b0} : {cmd_stat[7:1], 1'b0};
  assign mem_wr   = fetched && (is_sie_reg || cmd_wr);

  // ********************************************
  // Answers
  // ********************************************
  // only the two read groups answer with data
  wire logic                rd_valid_next  = fetched && !is_sie_reg && is_read;
  // bit 1 goes out as stored; bit 0 reads zero
  wire logic [STAT_W-1:0]   rd_data_next   = fetched ? {cur_stat[7:1], 1'b0} : rd_data_out;
  // status read clears the endpoint interrupt
  wire logic                int_clear_next = fetched && !is_sie_reg && is_status;
  wire logic [EP_IDX_W-1:0] int_idx_next   = fetched ? cur_idx : int_clear_idx_out;
  wire logic                sie_answer     = fetched && is_sie_reg;
  wire logic                stall_next     = sie_answer ? (ep_stalled && !auto_unstall) : sie_stall_out;
  wire logic                nak_next       = sie_answer ? out_nak : sie_nak_out;

  // Busy mirrors the sequencer, so requests wait for idle
  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= (state_next != UEPSC_IDLE);
    end
  end

  // image read only answers; it writes nothing back
  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      rd_valid_out      <= 1'b0;
      rd_data_out       <= STATUS_RESET;
      int_clear_out     <= 1'b0;
      int_clear_idx_out <= 4'h0;
    end else begin
      rd_valid_out      <= rd_valid_next;
      rd_data_out       <= rd_data_next;
      int_clear_out     <= int_clear_next;
      int_clear_idx_out <= int_idx_next;
    end
  end

  // Serial engine replies stand until the next event
  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      sie_nak_out   <= 1'b0;
      sie_stall_out <= 1'b0;
    end else begin
      sie_nak_out   <= nak_next;
      sie_stall_out <= stall_next;
    end
  end

endmodule // uepsc_top

//--- verification/testbench.sv
// Self-checking bench for the endpoint status block
`timescale 1ns/10ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin n_fail++; $display("FAIL %s exp %h got %h", n, e, a); end end
module testbench;
  logic       clock_in = 1'b0;
  logic       rstn_in = 1'b0;
  logic       cmd_valid_in, rd_valid_out, int_clear_out, busy_out, sie_nak_out, sie_stall_out;
  logic [7:0] cmd_code_in, rd_data_out;
  logic [3:0] int_clear_idx_out;
  logic       sie_valid_in = 1'b0;
  logic [3:0] sie_idx_in = 4'h0;
  logic [4:0] ev = 5'h00;
  int         n_fail = 0;
  int         compares = 0;
  always #2 clock_in = ~clock_in;
  uepsc_top u_uepsc_top (.clock_in, .rstn_in, .cmd_valid_in, .cmd_code_in, .rd_valid_out, .rd_data_out,
    .int_clear_out, .int_clear_idx_out, .busy_out, .ep_is_in_in(16'h0016), .ep_double_buf_in(16'h0010),
    .sie_valid_in, .sie_idx_in, .sie_setup_token_in(ev[4]), .sie_setup_done_in(ev[3]),
    .sie_out_done_in(ev[2]), .sie_in_sent_in(ev[1]), .sie_setup_ack_in(ev[0]), .sie_nak_out, .sie_stall_out);
  uepsc_cpu_model u_uepsc_cpu_model (.clock_in, .busy_in(busy_out), .rd_valid_in(rd_valid_out),
    .rd_data_in(rd_data_out), .cmd_valid_out(cmd_valid_in), .cmd_code_out(cmd_code_in));
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    logic       g;
    logic [7:0] d;
    u_uepsc_cpu_model.xfer(c, g, d);
    `CHK("answer", 1'b1, g)
    `CHK("status", e, d)
  endtask
  task automatic op(input logic [7:0] c);
    logic       g;
    logic [7:0] d;
    u_uepsc_cpu_model.xfer(c, g, d);
    `CHK("no answer", 1'b0, g)
  endtask
  task automatic sie(input logic [3:0] i, input logic [4:0] f);
    @(negedge clock_in);
    while (busy_out) @(negedge clock_in);
    sie_idx_in   = i;
    ev           = f;
    sie_valid_in = 1'b1;
    @(negedge clock_in);
    sie_valid_in = 1'b0;
    ev           = ~f;
    repeat (4) @(negedge clock_in);
  endtask
  task automatic endt(input string s);
    $display("test %s done", s);
  endtask
  task automatic final_report();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #40000;
    n_fail++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge clock_in);
    @(negedge clock_in) rstn_in = 1'b1;
    repeat (4) @(negedge clock_in);
    for (int i = 0; i < 16; i++) begin
      rd({4'hd, i[3:0]}, 8'h00);
      op({4'h4, i[3:0]});
      rd({4'hd, i[3:0]}, 8'h80);
      op({4'h8, i[3:0]});
      rd({4'hd, i[3:0]}, 8'h00);
    end
    endt("stall codes");
    op(8'h43);
    sie(4'h3, 5'b00100);
    `CHK("stall reply", 1'b1, sie_stall_out)
    op(8'h83);
    rd(8'hd3, 8'h00);
    endt("stall reply");
    op(8'h62);
    rd(8'hd2, 8'h20);
    sie(4'h2, 5'b00010);
    rd(8'hd2, 8'h10);
    op(8'h42);
    op(8'h82);
    rd(8'hd2, 8'h00);
    op(8'h64);
    rd(8'hd4, 8'h22);
    op(8'h64);
    rd(8'hd4, 8'h60);
    endt("in buffers");
    sie(4'h5, 5'b00100);
    rd(8'h55, 8'h30);
    rd(8'hd5, 8'h30);
    sie(4'h5, 5'b00100);
    `CHK("nak", 1'b1, sie_nak_out)
    op(8'h71);
    rd(8'hd1, 8'h00);
    op(8'h75);
    rd(8'hd5, 8'h10);
    sie(4'h5, 5'b00100);
    `CHK("nak", 1'b0, sie_nak_out)
    endt("out buffers");
    op(8'h40);
    sie(4'h0, 5'b10000);
    `CHK("stall reply", 1'b0, sie_stall_out)
    sie(4'h0, 5'b01000);
    rd(8'hd0, 8'h34);
    sie(4'h0, 5'b10000);
    rd(8'hd0, 8'h3c);
    sie(4'h0, 5'b01000);
    rd(8'h50, 8'h3c);
    rd(8'hd0, 8'h34);
    sie(4'h0, 5'b00001);
    rd(8'hd0, 8'h30);
    op(8'h70);
    rd(8'hd0, 8'h10);
    endt("setup");
    final_report();
  end
endmodule // testbench

//--- verification/uepsc_chk.sv
// Port checker for the endpoint status block
`timescale 1ns/10ps
module uepsc_chk (
  input wire logic       clock_in,
  input wire logic       rstn_in,
  input wire logic       cmd_valid_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic       sie_valid_in,
  input wire logic       busy_out,
  input wire logic       rd_valid_out,
  input wire logic [7:0] rd_data_out,
  input wire logic       int_clear_out,
  input wire logic [3:0] int_clear_idx_out
);
  logic       take;
  logic       is_read;
  logic [7:0] code_reg;
  assign take    = cmd_valid_in && !busy_out && !sie_valid_in;
  assign is_read = (cmd_code_in[7:4] == 4'h5) || (cmd_code_in[7:4] == 4'hd);
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) code_reg <= 8'h00;
    else if (take) code_reg <= cmd_code_in;
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  read_answer_a: assert property (take && is_read |-> ##[1:4] rd_valid_out)
    else $error("read command got no answer");
  no_answer_a: assert property (take && !is_read |=> !rd_valid_out [*4])
    else $error("non-read command gave read data");
  busy_take_a: assert property (take |=> busy_out)
    else $error("busy not raised after command");
  rd_pulse_a: assert property (rd_valid_out |=> !rd_valid_out)
    else $error("read valid longer than one cycle");
  reserved_zero_a: assert property (rd_valid_out |-> rd_data_out[0] == 1'b0)
    else $error("reserved status bit set");
  status_clear_a: assert property (rd_valid_out && code_reg[7:4] == 4'h5
    |-> int_clear_out && int_clear_idx_out == code_reg[3:0])
    else $error("status read did not clear its endpoint");
  image_keep_a: assert property (rd_valid_out && code_reg[7:4] == 4'hd |-> !int_clear_out)
    else $error("image read cleared interrupt");
  clear_alone_a: assert property (int_clear_out |-> rd_valid_out && $past(busy_out))
    else $error("interrupt clear without status read");
  cover property (take && cmd_code_in[7:4] == 4'h4);
  cover property (rd_valid_out && int_clear_out);
  cover property (take && cmd_code_in[7:4] == 4'h6);
endmodule // uepsc_chk
bind uepsc_top uepsc_chk u_uepsc_chk (.clock_in, .rstn_in, .cmd_valid_in, .cmd_code_in, .sie_valid_in,
  .busy_out, .rd_valid_out, .rd_data_out, .int_clear_out, .int_clear_idx_out);

//--- verification/uepsc_cpu_model.sv
// Processor model issuing endpoint commands
`timescale 1ns/10ps
module uepsc_cpu_model (
  input  wire logic       clock_in,
  input  wire logic       busy_in,
  input  wire logic       rd_valid_in,
  input  wire logic [7:0] rd_data_in,
  output logic            cmd_valid_out,
  output logic      [7:0] cmd_code_out
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_code_out  = 8'h00;
  end
  task automatic xfer(input logic [7:0] c, output logic g, output logic [7:0] d);
    g = 1'b0;
    d = 8'h00;
    @(negedge clock_in);
    while (busy_in) @(negedge clock_in);
    cmd_code_out  = c;
    cmd_valid_out = 1'b1;
    @(negedge clock_in);
    cmd_valid_out = 1'b0;
    cmd_code_out  = ~c;
    repeat (5) begin
      @(negedge clock_in);
      if (rd_valid_in === 1'b1) begin
        g = 1'b1;
        d = rd_data_in;
      end
    end
  endtask
endmodule // uepsc_cpu_model
